/* rtl/blo_pkg.sv */
// package: register map, field layout and constants of the black/offset block
// Notes on behaviour
// - Bits 5:3 of the coefficient register set how many top bits of a black sample are dropped; 000 drops none.
// - Codes 001 to 111 drop the top one to seven bits of the 12-bit black sample, keeping bits 10:0 down to 4:0.
// - Bits 2:0 of the coefficient register hold the exponential averaging coefficient for black samples.
// - A larger coefficient makes the black level estimate converge more slowly.
// - Threshold 0 high register bits 7:0 give threshold 0 bits 11:4.
// - Threshold 0 low register bits 7:4 give threshold 0 bits 3:0; its bits 3:0 are reserved.
// - Threshold 1 is built from its high register as bits 11:4 and low register bits 7:4 as bits 3:0.
// - Offset register bit 7 chooses direction: 0 adds, 1 subtracts.
// - Offset register bits 6:1 hold the six-bit offset magnitude.
// - The coefficient register sits at address 26h, is read/write and resets to zero.
package blo_pkg;
   localparam int          DATA_W        = 12;
   localparam int          ADDR_W        = 8;
   localparam int          FRAC_W        = 8;
   localparam logic [7:0]  ADDR_COEFF    = 8'h26;
   localparam logic [7:0]  ADDR_TH0_HI   = 8'h27;
   localparam logic [7:0]  ADDR_TH0_LO   = 8'h28;
   localparam logic [7:0]  ADDR_TH1_HI   = 8'h29;
   localparam logic [7:0]  ADDR_TH1_LO   = 8'h2a;
   localparam logic [7:0]  ADDR_OFFSET   = 8'h2b;
   localparam logic [7:0]  REG_RESET     = 8'h00;
   localparam logic [7:0]  COEFF_MASK    = 8'h3f;
   localparam logic [7:0]  LOW_MASK      = 8'hf0;
   localparam logic [7:0]  OFFSET_MASK   = 8'hfe;
   localparam int          CLIP_MSB      = 5;
   localparam int          CLIP_LSB      = 3;
   localparam int          ALPHA_MSB     = 2;
   localparam int          ALPHA_LSB     = 0;
   localparam int          OFF_SIGN_BIT  = 7;
   localparam int          OFF_MAG_MSB   = 6;
   localparam int          OFF_MAG_LSB   = 1;
   localparam int          LOW_NIB_MSB   = 7;
   localparam int          LOW_NIB_LSB   = 4;
   localparam logic [2:0]  CLIP_NONE     = 3'h0;
   localparam logic [11:0] FULL_SCALE    = 12'hfff;
   localparam int          REG_COUNT     = 6;
   localparam int          REG_IDX_W     = 3;
endpackage : blo_pkg

/* rtl/blo_regfile.sv */
// register store: six byte registers, registered read data
`timescale 1ns/1ps
module blo_regfile #(
   parameter int DEPTH = 6,
   parameter int IDX_W = 3
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             clk_en,
   // write side
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [7:0]       wr_data,
   input  wire logic [7:0]       wr_mask,
   // read side
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [7:0]       rd_data,
   // all registers, flat
   output logic      [8*DEPTH-1:0] regs_flat
);
   import blo_pkg::*;
   logic [7:0] mem_q [DEPTH];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= REG_RESET;
         rd_data <= REG_RESET;
      end else if (clk_en) begin
         if (wr_en) mem_q[wr_idx] <= wr_data & wr_mask;
         rd_data <= mem_q[rd_idx];
      end
   end

   always_comb begin
      for (int i = 0; i < DEPTH; i++) regs_flat[8*i +: 8] = mem_q[i];
   end
endmodule : blo_regfile

/* rtl/blo_core.sv */
// black level clipping/averaging, offset correction and threshold registers
`timescale 1ns/1ps
module blo_core #(
   parameter int DW = blo_pkg::DATA_W,
   parameter int FW = blo_pkg::FRAC_W
) (
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic                   clk_en,
   // configuration port (byte registers)
   input  wire logic                   cfg_wr,
   input  wire logic                   cfg_rd,
   input  wire logic [blo_pkg::ADDR_W-1:0] cfg_addr,
   input  wire logic [7:0]             cfg_wdata,
   output logic      [7:0]             cfg_rdata,
   output logic                        cfg_rvalid,
   // black pixel samples
   input  wire logic                   black_valid,
   input  wire logic [DW-1:0]          black_data,
   // video pixels in
   input  wire logic                   pix_valid,
   input  wire logic [DW-1:0]          pix_data,
   // video pixels out
   output logic                        out_valid,
   output logic      [DW-1:0]          out_data,
   // settings to the defect corrector and status
   output logic      [DW-1:0]          defect_threshold_zero,
   output logic      [DW-1:0]          defect_threshold_one,
   output logic      [DW-1:0]          black_level
);
   import blo_pkg::*;

   // register index decode: 0 coeff .. 5 offset
   function automatic logic [REG_IDX_W-1:0] addr_idx(input logic [7:0] a);
      return REG_IDX_W'(a - ADDR_COEFF);
   endfunction
   function automatic logic addr_hit(input logic [7:0] a);
      return (a >= ADDR_COEFF) && (a <= ADDR_OFFSET);
   endfunction
   function automatic logic [7:0] addr_mask(input logic [7:0] a);
      return (a == ADDR_COEFF)  ? COEFF_MASK :
             (a == ADDR_OFFSET) ? OFFSET_MASK :
             (a == ADDR_TH0_LO || a == ADDR_TH1_LO) ? LOW_MASK : 8'hff;
   endfunction

   logic [8*REG_COUNT-1:0] regs_flat;
   logic [7:0]             rf_rdata;
   logic                   rd_hit_q;
   logic                   rd_pend_q;

   blo_regfile #(
      .DEPTH (REG_COUNT),
      .IDX_W (REG_IDX_W)
   ) u_regs (
      .core_clk  (core_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .wr_en     (cfg_wr && addr_hit(cfg_addr)),
      .wr_idx    (addr_idx(cfg_addr)),
      .wr_data   (cfg_wdata),
      .wr_mask   (addr_mask(cfg_addr)), // reserved bits, incl. bit
      .rd_idx    (addr_idx(cfg_addr)),
      .rd_data   (rf_rdata),
      .regs_flat (regs_flat)
   );

   wire [7:0] coeff_reg  = regs_flat[0*8 +: 8];
   wire [7:0] th0_hi     = regs_flat[1*8 +: 8];
   wire [7:0] th0_lo     = regs_flat[2*8 +: 8];
   wire [7:0] th1_hi     = regs_flat[3*8 +: 8];
   wire [7:0] th1_lo     = regs_flat[4*8 +: 8];
   wire [7:0] offset_reg = regs_flat[5*8 +: 8];

   wire [2:0] clip_code  = coeff_reg[CLIP_MSB:CLIP_LSB];
   wire [2:0] alpha      = coeff_reg[ALPHA_MSB:ALPHA_LSB];
   wire       off_dir    = offset_reg[OFF_SIGN_BIT];
   wire [5:0] off_mag    = offset_reg[OFF_MAG_MSB:OFF_MAG_LSB];

   // clipping: keep the low DW-code bits, code 0 keeps all
   wire [DW-1:0] clip_keep = {DW{1'b1}} >> clip_code;
   wire [DW-1:0] black_clipped = black_data & clip_keep;

   // averaging: est += (x - est) >> alpha, est carries FW fraction bits
   logic [DW+FW-1:0] est_q;
   wire  signed [DW+FW+1:0] err =
      $signed({2'b00, black_clipped, {FW{1'b0}}}) - $signed({2'b00, est_q});
   wire  signed [DW+FW+1:0] step = err >>> alpha;
   wire  [DW+FW+1:0] est_sum = (DW+FW+2)'($signed({2'b00, est_q}) + step);
   wire  [DW-1:0] black_est = est_q[DW+FW-1:FW];

   // offset after compensation, saturating
   wire signed [DW+1:0] comp =
      $signed({2'b00, pix_data}) - $signed({2'b00, black_est});
   wire signed [DW+1:0] offs =
      off_dir ? comp - $signed({{(DW-4){1'b0}}, off_mag})
              : comp + $signed({{(DW-4){1'b0}}, off_mag});
   wire [DW-1:0] pix_sat =
      (offs < 0) ? '0 :
      (offs > $signed({2'b00, FULL_SCALE})) ? FULL_SCALE
                                            : offs[DW-1:0];

   wire [DW-1:0] th0_val = {th0_hi, th0_lo[LOW_NIB_MSB:LOW_NIB_LSB]};
   wire [DW-1:0] th1_val = {th1_hi, th1_lo[LOW_NIB_MSB:LOW_NIB_LSB]};

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         est_q <= '0;
      end else if (clk_en && black_valid) begin
         est_q <= est_sum[DW+FW-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (clk_en) begin
         out_valid <= pix_valid;
         if (pix_valid) out_data <= pix_sat;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         defect_threshold_zero <= '0;
         defect_threshold_one  <= '0;
         black_level           <= '0;
         rd_pend_q             <= 1'b0;
         rd_hit_q              <= 1'b0;
         cfg_rvalid            <= 1'b0;
         cfg_rdata             <= '0;
      end else if (clk_en) begin
         defect_threshold_zero <= th0_val;
         defect_threshold_one  <= th1_val;
         black_level           <= black_est;
         rd_pend_q             <= cfg_rd;
         rd_hit_q              <= addr_hit(cfg_addr);
         cfg_rvalid            <= rd_pend_q;
         cfg_rdata             <= rd_hit_q ? rf_rdata : 8'h00;
      end
   end

   // checks
   property p_clip_off;
      @(posedge core_clk) disable iff (rst)
      (clip_code == CLIP_NONE) |-> (black_clipped == black_data);
   endproperty
   a_clip_off: assert property (p_clip_off) else $error("clip0 changed");

   property p_clip_top;
      @(posedge core_clk) disable iff (rst)
      (clip_code != CLIP_NONE) |->
         ((black_clipped >> (DW - clip_code)) == '0);
   endproperty
   a_clip_top: assert property (p_clip_top) else $error("top bits kept");

   property p_th0;
      @(posedge core_clk) disable iff (rst)
      clk_en |=> defect_threshold_zero == {$past(th0_hi), $past(th0_lo[7:4])};
   endproperty
   a_th0: assert property (p_th0) else $error("threshold 0 wrong");

   property p_th0_lo_res;
      @(posedge core_clk) disable iff (rst) th0_lo[3:0] == 4'h0;
   endproperty
   a_th0_lo_res: assert property (p_th0_lo_res) else $error("res bits");

   property p_th1;
      @(posedge core_clk) disable iff (rst)
      clk_en |=> defect_threshold_one == {$past(th1_hi), $past(th1_lo[7:4])};
   endproperty
   a_th1: assert property (p_th1) else $error("threshold 1 wrong");

   property p_off_dir;
      @(posedge core_clk) disable iff (rst)
      (clk_en && pix_valid && comp >= 64 && comp < 4000) |=>
         out_data == ($past(off_dir) ? $past(comp[DW-1:0]) - $past(off_mag)
                                     : $past(comp[DW-1:0]) + $past(off_mag));
   endproperty
   a_off_dir: assert property (p_off_dir) else $error("offset wrong");

   property p_off_res;
      @(posedge core_clk) disable iff (rst) offset_reg[0] == 1'b0;
   endproperty
   a_off_res: assert property (p_off_res) else $error("bit0 set");

   property p_coeff_rd;
      @(posedge core_clk) disable iff (rst)
      (clk_en && cfg_rd && !cfg_wr && cfg_addr == ADDR_COEFF) ##1 clk_en
         |=> cfg_rvalid && cfg_rdata == $past(coeff_reg, 2);
   endproperty
   a_coeff_rd: assert property (p_coeff_rd) else $error("coeff read");

   property p_est_hold;
      @(posedge core_clk) disable iff (rst)
      !black_valid |=> $stable(est_q);
   endproperty
   a_est_hold: assert property (p_est_hold) else $error("estimate moved");

   property p_sat;
      @(posedge core_clk) disable iff (rst)
      (clk_en && pix_valid && offs < 0) |=> out_data == '0;
   endproperty
   a_sat: assert property (p_sat) else $error("no floor");

   // a low enable must freeze the estimate, the pixel path and the bus answer
   property p_freeze;
      @(posedge core_clk) disable iff (rst)
      !clk_en |=> $stable(est_q) && $stable(out_data) && $stable(cfg_rvalid);
   endproperty
   a_freeze: assert property (p_freeze) else $error("frozen");

   property p_rd_hole;
      @(posedge core_clk) disable iff (rst)
      (clk_en && cfg_rd && !addr_hit(cfg_addr)) ##1 clk_en
         |=> cfg_rvalid && cfg_rdata == 8'h00;
   endproperty
   a_rd_hole: assert property (p_rd_hole) else $error("gap");

   c_clip: cover property (@(posedge core_clk) black_valid && clip_code == 3'h7);
   c_sub:  cover property (@(posedge core_clk) pix_valid && off_dir && off_mag != 0);
   c_sat:  cover property (@(posedge core_clk) pix_valid && pix_sat == FULL_SCALE);
   c_hold: cover property (@(posedge core_clk) !clk_en && pix_valid);
endmodule : blo_core

/* verif/tb_top.sv */
// testbench: register access, black level, offset and threshold checks
`timescale 1ns/1ps
module tb_top;
   import blo_pkg::*;
   logic        core_clk    = 1'b0;
   logic        rst         = 1'b1;
   logic        clk_en      = 1'b1;
   logic        cfg_wr      = 1'b0;
   logic        cfg_rd      = 1'b0;
   logic [7:0]  cfg_addr    = 8'h00;
   logic [7:0]  cfg_wdata   = 8'h00;
   logic [7:0]  cfg_rdata;
   logic        cfg_rvalid;
   logic        black_valid = 1'b0;
   logic [11:0] black_data  = 12'h000;
   logic        pix_valid   = 1'b0;
   logic [11:0] pix_data    = 12'h000;
   logic        out_valid;
   logic [11:0] out_data;
   logic [11:0] th0;
   logic [11:0] th1;
   logic [11:0] black_level;
   int          n_errors    = 0;
   int          check_count = 0;
   int          cycles      = 0;

   always #12.5 core_clk = ~core_clk;

   blo_core dut (
      .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .black_valid(black_valid),
      .black_data(black_data), .pix_valid(pix_valid),
      .pix_data(pix_data), .out_valid(out_valid), .out_data(out_data),
      .defect_threshold_zero(th0), .defect_threshold_one(th1),
      .black_level(black_level)
   );

   task conclude();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // the whole run needs about 300 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         $display("mismatch at %0t: run did not finish", $time);
         conclude();
      end
   end

   task chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk); #1;
      cfg_wr = 1'b1; cfg_addr = a; cfg_wdata = d;
      @(posedge core_clk); #1;
      cfg_wr = 1'b0; cfg_wdata = ~d;
   endtask : wr

   // read data stand two enabled edges after the request, for one cycle only
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk); #1;
      cfg_rd = 1'b1; cfg_addr = a;
      @(posedge core_clk); #1;
      cfg_rd = 1'b0;
      @(posedge core_clk);
      #1 chk({11'h000, cfg_rvalid}, 12'h001, "read valid");
      chk({4'h0, cfg_rdata}, {4'h0, exp}, "read data");
      @(posedge core_clk);
      #1 chk({11'h000, cfg_rvalid}, 12'h000, "read valid pulse");
   endtask : rd_chk

   // one black sample with the given coefficient byte
   task blk(input logic [7:0] coeff, input logic [11:0] x,
            input logic [11:0] exp);
      wr(ADDR_COEFF, coeff);
      @(posedge core_clk); #1;
      black_valid = 1'b1; black_data = x;
      @(posedge core_clk); #1;
      black_valid = 1'b0; black_data = ~x;
      repeat (3) @(posedge core_clk);
      #1 chk(black_level, exp, "black level");
   endtask : blk

   task pix(input logic [11:0] p, input logic [11:0] exp);
      @(posedge core_clk); #1;
      pix_valid = 1'b1; pix_data = p;
      @(posedge core_clk); #1;
      pix_valid = 1'b0; pix_data = ~p;
      chk({11'h000, out_valid}, 12'h001, "pixel valid");
      chk(out_data, exp, "pixel data");
   endtask : pix

   logic [7:0] rmask [6] = '{8'h3f, 8'hff, 8'hf0, 8'hff, 8'hf0, 8'hfe};

   initial begin
      repeat (4) @(posedge core_clk);
      #1 rst = 1'b0;
      for (int k = 0; k < 6; k++)
         rd_chk(ADDR_COEFF + 8'(k), REG_RESET);
      rd_chk(8'h30, 8'h00);
      // 2eh folds onto the coefficient slot in the index; must be ignored
      wr(8'h2e, 8'h3f);
      rd_chk(ADDR_COEFF, REG_RESET);
      // all ones written to the first five, fe to the offset; reserved bits must read back zero
      for (int k = 0; k < 5; k++) wr(ADDR_COEFF + 8'(k), 8'hff);
      wr(ADDR_OFFSET, 8'hfe);
      for (int k = 0; k < 6; k++)
         rd_chk(ADDR_COEFF + 8'(k), rmask[k]);
      wr(ADDR_TH0_HI, 8'hab);
      wr(ADDR_TH0_LO, 8'hc5);
      wr(ADDR_TH1_HI, 8'h12);
      wr(ADDR_TH1_LO, 8'h3f);
      repeat (2) @(posedge core_clk);
      #1 chk(th0, 12'habc, "threshold zero");
      chk(th1, 12'h123, "threshold one");
      // alpha zero replaces the estimate with the clipped sample
      for (int c = 0; c < 8; c++)
         blk({2'b00, 3'(c), 3'b000}, 12'ha5c,
             12'ha5c & (12'hfff >> c));
      for (int a = 0; a < 8; a++) begin
         blk(8'h00, 12'h000, 12'h000);
         blk({5'h00, 3'(a)}, 12'h800, 12'h800 >> a);
      end
      blk(8'h00, 12'h100, 12'h100);
      // enable low: a write and both strobes must leave every state alone
      clk_en = 1'b0;
      wr(ADDR_TH0_HI, 8'h55);
      black_valid = 1'b1;
      black_data = 12'hfff;
      pix_valid = 1'b1;
      pix_data = 12'h800;
      repeat (2) @(posedge core_clk);
      #1 chk({11'h000, out_valid}, 12'h000, "frozen valid");
      chk(black_level, 12'h100, "frozen black level");
      black_valid = 1'b0;
      pix_valid = 1'b0;
      clk_en = 1'b1;
      rd_chk(ADDR_TH0_HI, 8'hab);
      chk(th0, 12'habc, "threshold after freeze");
      chk(black_level, 12'h100, "black level after freeze");
      wr(ADDR_OFFSET, 8'h7e);
      pix(12'h200, 12'h13f);
      wr(ADDR_OFFSET, 8'hfe);
      pix(12'h200, 12'h0c1);
      pix(12'h120, 12'h000);
      blk(8'h00, 12'h000, 12'h000);
      wr(ADDR_OFFSET, 8'h7e);
      pix(12'hffe, 12'hfff);
      // second reset in mid-run: registers and outputs back to zero
      rst = 1'b1;
      @(posedge core_clk);
      #1 rst = 1'b0;
      chk(out_data, 12'h000, "pixel after reset");
      chk(th0, 12'h000, "threshold after reset");
      chk(black_level, 12'h000, "black level after reset");
      rd_chk(ADDR_OFFSET, REG_RESET);
      rd_chk(ADDR_COEFF, REG_RESET);
      conclude();
   end
endmodule : tb_top
